// File: pkg/trace_fmt_pkg.sv
package trace_fmt_pkg;

    // Bus register offsets (byte addresses)
    localparam logic [7:0] ctrl_b_offset        = 8'h04;
    localparam logic [7:0] ctrl_c_offset        = 8'h08;
    localparam logic [7:0] ctrl_a_offset        = 8'h00;
    localparam logic [7:0] status_offset        = 8'h0c;
    localparam logic [7:0] ident_offset         = 8'h10;

    // Control field positions
    localparam int         ca_bit               = 0;
    localparam int         miss_fcr_bit         = 11;
    localparam int         pcv_en_bit           = 12;
    localparam int         drop_lsb_bit         = 13;
    localparam int         adw_bit              = 0;
    localparam int         trace_on_bit         = 1;
    localparam int         order_field_width_lo             = 0;

    // Reset values
    localparam logic [31:0] ctrl_a_reset        = 32'h0000_0000;
    localparam logic [31:0] ctrl_b_reset        = 32'h0000_0000;
    localparam logic [3:0]  order_field_width_reset         = 4'h4;
    // Arbitrary identification value
    localparam logic [31:0] ident_value         = 32'h0000_5a5a;

    // Trace encodings
    localparam logic [2:0] no_data_trace        = 3'h0;
    localparam logic [2:0] data_trace_code      = 3'h1;
    localparam logic [1:0] completion_hdr       = 2'h2;
    localparam logic [2:0] full_info_hdr        = 3'h0;

    // Format widths
    localparam logic [6:0] stall_len            = 7'h01;
    localparam logic [6:0] completion_len       = 7'h05;
    localparam logic [6:0] full_info_len_16     = 7'h1b;
    localparam logic [6:0] full_info_len_32     = 7'h2b;
    localparam logic [6:0] overflow_len         = 7'h04;
    localparam int         fmt_max              = 64;

    // Miss indication arrives this many cycles after the completion message
    localparam int         miss_offset_cycles   = 2;

    typedef enum logic [1:0] {idle_s, busy_s} ser_state_t;

endpackage

// File: logic/fmt_shift_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Holds one format word; bit 0 leaves first, next word loads back to back
module fmt_shift_reg
    import trace_fmt_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic                 load_i,
    input  wire logic [fmt_max-1:0]   word_i,
    input  wire logic [6:0]           len_i,
    output logic                      busy_o,
    output logic                      bit_o,
    output logic                      bit_valid_o
);
    logic [fmt_max-1:0] shreg;
    logic [6:0]         left;

    assign busy_o = (left > 7'h01);

    // Serialiser: one bit a cycle from bit 0
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            shreg       <= '0;
            left        <= 7'h00;
            bit_o       <= 1'b0;
            bit_valid_o <= 1'b0;
        end
        else if (load_i && !busy_o)
        begin
            bit_o       <= word_i[0];
            bit_valid_o <= (len_i != 7'h00);
            shreg       <= word_i >> 1;
            left        <= len_i;
        end
        else
        begin
            bit_o       <= shreg[0];
            bit_valid_o <= (left > 7'h01);
            shreg       <= shreg >> 1;
            left        <= (left != 7'h00) ? left - 7'h01 : 7'h00;
        end
    end
endmodule // fmt_shift_reg
`default_nettype wire

// File: logic/trace_format_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module trace_format_encoder
    import trace_fmt_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // AHB-Lite slave
    input  wire logic         hsel_i,
    input  wire logic [7:0]   haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic [31:0]  hwdata_i,
    input  wire logic         hready_i,
    output logic [31:0]       hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    // Core trace inputs, same clock
    input  wire logic         trace_valid_i,
    input  wire logic [2:0]   instr_complete_code_i,
    input  wire logic [2:0]   trace_type_i,
    input  wire logic         trace_end_flag_i,
    input  wire logic         trace_mode_field_i,
    input  wire logic [31:0]  addr_data_i,
    input  wire logic [15:0]  byte_order_field_i,
    input  wire logic         icache_miss_flag_i,
    input  wire logic         call_return_hint_i,
    input  wire logic         loadstore_miss_flag_i,
    input  wire logic         perf_counter_valid_i,
    input  wire logic         overflow_i,
    input  wire logic         wait_state_i,
    input  wire logic [31:0]  pc_value_i,
    // Trace memory side, and the core stall
    output logic              fmt_valid_o,
    output logic [fmt_max-1:0] fmt_word_o,
    output logic [6:0]        fmt_len_o,
    output logic              trace_bit_o,
    output logic              trace_bit_valid_o,
    output logic              stall_core_o
);
    logic [31:0] trace_ctrl_a;
    logic [31:0] trace_ctrl_b;
    logic [3:0]  order_field_width;
    logic        sess_miss_fcr;
    logic        sess_pcv;
    logic        sess_ca;
    logic        sess_drop;
    logic        sess_adw32;
    logic        resync_pending;
    logic [miss_offset_cycles-1:0] miss_pipe;

    // Address phase capture
    logic        dp_write;
    logic        dp_read;
    logic [7:0]  dp_addr;
    wire         addr_ok   = hsel_i && hready_i && htrans_i[1];
    wire         trace_on  = trace_ctrl_a[trace_on_bit];

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 8'h00;
        end
        else
        begin
            dp_write <= addr_ok && hwrite_i;
            dp_read  <= addr_ok && !hwrite_i;
            dp_addr  <= haddr_i;
        end
    end

    // Register writes in data phase
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            trace_ctrl_a      <= ctrl_a_reset;
            trace_ctrl_b      <= ctrl_b_reset;
            order_field_width <= order_field_width_reset;
        end
        else if (dp_write)
        begin
            if (dp_addr == ctrl_a_offset)
                trace_ctrl_a <= hwdata_i;
            if (dp_addr == ctrl_b_offset)
                trace_ctrl_b <= hwdata_i;
            if (dp_addr == ctrl_c_offset)
                order_field_width <= hwdata_i[order_field_width_lo +: 4];
        end
    end

    // Read mux, registered in the address phase
    wire [31:0] status_word = {28'h0, resync_pending, stall_core_o, trace_bit_valid_o, trace_on};
    wire [31:0] rd_mux =
        (haddr_i == ctrl_a_offset) ? trace_ctrl_a :
        (haddr_i == ctrl_b_offset) ? trace_ctrl_b :
        (haddr_i == ctrl_c_offset) ? {28'h0, order_field_width} :
        (haddr_i == status_offset) ? status_word :
        (haddr_i == ident_offset)  ? ident_value : 32'h0000_0000;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            hrdata_o <= 32'h0000_0000;
        else if (addr_ok && !hwrite_i)
            hrdata_o <= rd_mux;
    end

    // Option bits latched when session starts, held while on
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sess_miss_fcr <= 1'b0;
            sess_pcv      <= 1'b0;
            sess_ca       <= 1'b0;
            sess_drop     <= 1'b0;
            sess_adw32    <= 1'b0;
        end
        else if (!trace_on)
        begin
            sess_miss_fcr <= trace_ctrl_b[miss_fcr_bit];
            sess_pcv      <= trace_ctrl_b[pcv_en_bit];
            sess_ca       <= trace_ctrl_b[ca_bit];
            sess_drop     <= trace_ctrl_b[drop_lsb_bit];
            sess_adw32    <= trace_ctrl_a[adw_bit];
        end
    end

    // Miss flag delayed to its fixed slot after the completion message
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            miss_pipe <= '0;
        else
            miss_pipe <= {miss_pipe[miss_offset_cycles-2:0], loadstore_miss_flag_i};
    end
    wire ls_miss = miss_pipe[miss_offset_cycles-1];

    // Overflow forces full program counter on the next valid trace cycle
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            resync_pending <= 1'b0;
        else if (trace_valid_i && trace_on)
            resync_pending <= overflow_i;
    end

    // Classification
    wire is_stall    = (instr_complete_code_i == 3'h0) && (trace_type_i == no_data_trace)
                       && !overflow_i && !resync_pending;
    wire is_compl    = (instr_complete_code_i != 3'h0) && (trace_type_i == no_data_trace)
                       && !overflow_i && !resync_pending;
    wire is_last     = (trace_type_i == data_trace_code) && trace_end_flag_i
                       && !perf_counter_valid_i && !overflow_i && !resync_pending;
    wire emit_stall  = is_stall && sess_ca && !wait_state_i;

    wire [6:0]  ad_w     = sess_adw32 ? 7'h20 : 7'h10;
    wire [31:0] ad_src   = resync_pending ? pc_value_i : addr_data_i;
    wire [31:0] ad_val   = sess_adw32 ? ad_src : {16'h0, ad_src[15:0]};
    wire [6:0]  bo_w     = {3'h0, order_field_width};
    wire [15:0] bo_mask  = 16'((17'h1 << order_field_width) - 17'h1);

    // Completion format
    wire [fmt_max-1:0] compl_word = {57'h0, call_return_hint_i, icache_miss_flag_i,
                                     instr_complete_code_i, completion_hdr};
    wire [6:0] compl_len = completion_len + (sess_miss_fcr ? 7'h02 : 7'h00);

    // Full-info low field, shared by last-data format
    wire [10:0] low_fields = {trace_mode_field_i,
                              resync_pending ? 1'b0 : trace_end_flag_i,
                              resync_pending ? data_trace_code : trace_type_i,
                              resync_pending ? 3'h0 : instr_complete_code_i,
                              full_info_hdr};

    // Optional bits: call/return lowest, then miss, then counter valid
    // Counter-valid bit kept out of the word unless the session counts it
    wire [2:0] full_opt  = {sess_pcv && perf_counter_valid_i, icache_miss_flag_i,
                            call_return_hint_i};
    wire [6:0] full_optw = (sess_miss_fcr ? 7'h02 : 7'h00) + (sess_pcv ? 7'h01 : 7'h00);
    wire [2:0] full_optm = sess_miss_fcr ? full_opt : {full_opt[2], 2'h0};
    wire [2:0] full_opts = sess_miss_fcr ? full_optm : {2'h0, full_optm[2]};
    wire [fmt_max-1:0] full_word = {{(fmt_max-11){1'b0}}, low_fields}
                                   | ({32'h0, ad_val} << 11)
                                   | ({61'h0, full_opts} << (7'd11 + ad_w));
    wire [6:0] full_base = (sess_adw32 ? full_info_len_32 : full_info_len_16) + full_optw;

    // Last-data format with byte order below address/data
    wire [2:0] last_opt = {ls_miss, icache_miss_flag_i, call_return_hint_i};
    wire [fmt_max-1:0] last_word = {{(fmt_max-11){1'b0}}, low_fields}
                                   | ({48'h0, byte_order_field_i & bo_mask} << 11)
                                   | ({32'h0, ad_val} << (7'd11 + bo_w))
                                   | ({61'h0, sess_miss_fcr ? last_opt : 3'h0}
                                      << (7'd11 + bo_w + ad_w));
    wire [6:0] last_len = (sess_adw32 ? full_info_len_32 : full_info_len_16) + bo_w
                          + (sess_miss_fcr ? 7'h03 : 7'h00);

    // Dropping the lowest header bit when not cycle accurate
    wire drop = sess_drop && !sess_ca;
    wire [fmt_max-1:0] big_word = is_last ? last_word : full_word;
    wire [6:0]         big_len  = is_last ? last_len : full_base;

    wire [fmt_max-1:0] next_word =
        overflow_i ? {{(fmt_max-4){1'b0}}, 4'h8} :
        emit_stall ? {{(fmt_max-1){1'b0}}, 1'b1} :
        is_compl   ? compl_word :
        drop       ? (big_word >> 1) : big_word;
    wire [6:0] next_len =
        overflow_i ? overflow_len :
        is_stall   ? (emit_stall ? stall_len : 7'h00) :
        is_compl   ? compl_len :
        drop       ? big_len - 7'h01 : big_len;

    wire take = trace_valid_i && trace_on && (next_len != 7'h00);
    logic ser_busy;
    assign stall_core_o = ser_busy;

    // Parallel format output
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            fmt_valid_o <= 1'b0;
            fmt_word_o  <= '0;
            fmt_len_o   <= 7'h00;
        end
        else
        begin
            fmt_valid_o <= take && !ser_busy;
            fmt_word_o  <= next_word;
            fmt_len_o   <= next_len;
        end
    end

    // Serial stream, header bits first
    fmt_shift_reg u_ser (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .load_i      (take),
        .word_i      (next_word),
        .len_i       (next_len),
        .busy_o      (ser_busy),
        .bit_o       (trace_bit_o),
        .bit_valid_o (trace_bit_valid_o)
    );
endmodule // trace_format_encoder
`default_nettype wire

// File: tb/trace_enc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the emitted formats and the serial stream
module trace_enc_asserts
    import trace_fmt_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    input  wire logic               trace_valid_i,
    input  wire logic [2:0]         instr_complete_code_i,
    input  wire logic [2:0]         trace_type_i,
    input  wire logic               trace_end_flag_i,
    input  wire logic               overflow_i,
    input  wire logic               wait_state_i,
    input  wire logic               fmt_valid_o,
    input  wire logic [fmt_max-1:0] fmt_word_o,
    input  wire logic [6:0]         fmt_len_o,
    input  wire logic               trace_bit_o,
    input  wire logic               trace_bit_valid_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Header patterns keep the parser in step
    stall_is_one_a: assert property (fmt_valid_o && fmt_len_o == 7'h01 |-> fmt_word_o[0])
        else $error("stall format not a one");
    compl_header_a: assert property (fmt_valid_o && fmt_len_o == 7'h05 |-> fmt_word_o[1:0] == 2'b10)
        else $error("completion header wrong");
    compl_code_a: assert property (fmt_valid_o && fmt_word_o[1:0] == 2'b10
        |-> fmt_word_o[4:2] == $past(instr_complete_code_i))
        else $error("completion code wrong");
    // Dropped lsb still leaves the two lowest bits zero
    full_header_a: assert property (fmt_valid_o && fmt_len_o > 7'h07 |-> fmt_word_o[1:0] == 2'b00)
        else $error("full format header wrong");
    last_pattern_a: assert property (fmt_valid_o && fmt_len_o > 7'h07 && !$past(overflow_i)
        && $past(trace_type_i) == data_trace_code && $past(trace_end_flag_i)
        |-> fmt_word_o[9:6] == 4'b1001)
        else $error("last data pattern wrong");
    wait_silent_a: assert property (trace_valid_i && wait_state_i && !overflow_i
        && instr_complete_code_i == 3'h0 && trace_type_i == 3'h0 |=> !fmt_valid_o)
        else $error("stall emitted while waiting");
    first_bit_a: assert property (fmt_valid_o |-> trace_bit_valid_o && trace_bit_o == fmt_word_o[0])
        else $error("bit zero not sent first");
    second_bit_a: assert property (fmt_valid_o && fmt_len_o > 7'h01
        |=> trace_bit_valid_o && trace_bit_o == $past(fmt_word_o[1]))
        else $error("bit one not sent second");
endmodule // trace_enc_asserts
`default_nettype wire

// File: tb/trace_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Trace memory: counts every serial bit and keeps the last 64, so gaps or extra bits show in the count
module trace_mem_model
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        trace_bit_i,
    input  wire logic        bit_valid_i,
    output logic [15:0]      bit_count_o,
    output logic [63:0]      recent_o
);
    // Bits arrive lsb first, so shift in from the top
    always_ff @(posedge mclk_i)
        if (rst_i)
        begin
            bit_count_o <= 16'h0;
            recent_o    <= 64'h0;
        end
        else if (bit_valid_i)
        begin
            bit_count_o <= bit_count_o + 16'h1;
            recent_o    <= {trace_bit_i, recent_o[63:1]};
        end
endmodule // trace_mem_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import trace_fmt_pkg::*;
    typedef struct packed {logic [63:0] w; logic [63:0] m; logic [6:0] l;} note_t;
    logic mclk_i, rst_i, hsel_i, hwrite_i, trace_valid_i, trace_end_flag_i, trace_mode_field_i;
    logic icache_miss_flag_i, call_return_hint_i, loadstore_miss_flag_i, wait_state_i;
    logic overflow_i, ovf, loadstore_miss_flag;
    logic [7:0] haddr_i;
    logic [1:0] htrans_i;
    logic [2:0] instr_complete_code_i, trace_type_i, cc;
    logic [31:0] hwdata_i, hrdata_o, addr_data_i, pc_value_i, q;
    logic [15:0] byte_order_field_i, bit_count;
    logic hreadyout_o, hresp_o, fmt_valid_o, trace_bit_o, trace_bit_valid_o, stall_core_o;
    logic [63:0] fmt_word_o, x, m;
    logic [6:0] fmt_len_o;
    note_t notes[$];
    int fail_count = 0, checked = 0, tot = 0, cyc = 0, b;

    trace_format_encoder trace_format_encoder_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .trace_valid_i(trace_valid_i),
        .instr_complete_code_i(instr_complete_code_i), .trace_type_i(trace_type_i),
        .trace_end_flag_i(trace_end_flag_i), .trace_mode_field_i(trace_mode_field_i),
        .addr_data_i(addr_data_i), .byte_order_field_i(byte_order_field_i),
        .icache_miss_flag_i(icache_miss_flag_i), .call_return_hint_i(call_return_hint_i),
        .loadstore_miss_flag_i(loadstore_miss_flag_i), .perf_counter_valid_i(1'b0),
        .overflow_i(overflow_i), .wait_state_i(wait_state_i), .pc_value_i(pc_value_i),
        .fmt_valid_o(fmt_valid_o), .fmt_word_o(fmt_word_o), .fmt_len_o(fmt_len_o),
        .trace_bit_o(trace_bit_o), .trace_bit_valid_o(trace_bit_valid_o),
        .stall_core_o(stall_core_o));
    trace_mem_model trace_mem_model_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .trace_bit_i(trace_bit_o), .bit_valid_i(trace_bit_valid_o),
        .bit_count_o(bit_count), .recent_o());

    // 200 MHz clock and a cycle ceiling well above the planned run
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end

    task automatic miss(input string s);
        fail_count++;
        $display("MISMATCH %0t %s", $time, s);
    endtask
    task automatic finish_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One AHB single transfer; read data taken at the data phase edge
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge mclk_i);
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        bus(a, 1'b0, 32'h0);
        checked++;
        if ((q & k) !== e) miss("register read");
    endtask
    // Present one core cycle; held until an edge with the serialiser free
    task automatic send(input logic [2:0] t, input logic e, input logic w);
        // Previous load/store miss lands in this cycle's slot
        loadstore_miss_flag = loadstore_miss_flag_i;
        // Look between edges so a load at this very edge is already visible
        @(negedge mclk_i);
        while (stall_core_o !== 1'b0) @(negedge mclk_i);
        @(posedge mclk_i);
        trace_valid_i <= 1'b1;
        overflow_i <= ovf;
        instr_complete_code_i <= cc;
        trace_type_i <= t;
        trace_end_flag_i <= e;
        wait_state_i <= w;
        {addr_data_i, pc_value_i} <= {$urandom, $urandom};
        byte_order_field_i <= 16'($urandom);
        {icache_miss_flag_i, call_return_hint_i, loadstore_miss_flag_i, trace_mode_field_i}
            <= 4'($urandom);
        @(posedge mclk_i);
        trace_valid_i <= 1'b0;
    endtask
    task automatic note(input logic [63:0] w, input logic [63:0] k, input int l);
        notes.push_back('{w & k, k, 7'(l)});
        tot += l;
    endtask
    // Walk the stall, completion, full and last-data formats under the given options
    task automatic phase(input bit o, input bit wd);
        logic [31:0] ad;
        cc = 3'h0;
        send(3'h0, 1'b0, 1'b0);
        note(64'h1, 64'h1, 1);
        send(3'h0, 1'b0, 1'b1);
        send(3'h0, 1'b0, 1'b0);
        note(64'h1, 64'h1, 1);
        for (int c = 1; c < 8; c++)
        begin
            cc = 3'(c);
            send(3'h0, 1'b0, 1'b0);
            note({59'h0, cc, 2'b10}, 64'h1f, o ? 7 : 5);
        end
        for (int t = 1; t < 9; t++)
        begin
            cc = 3'($urandom);
            send(t == 8 ? data_trace_code : 3'(t), t == 8, 1'b0);
            ad = wd ? addr_data_i : {16'h0, addr_data_i[15:0]};
            b = t == 8 ? (wd ? 47 : 31) : (wd ? 43 : 27);
            x = {21'h0, ad, trace_mode_field_i, 1'b0, 3'(t), cc, 3'b000};
            if (t == 8)
                x = {17'h0, ad, byte_order_field_i[3:0], trace_mode_field_i, 4'b1001, cc, 3'h0};
            if (o)
                x = x | ({61'h0, loadstore_miss_flag && t == 8, icache_miss_flag_i, call_return_hint_i} << b);
            m = (64'h1 << (b + (o ? (t == 8 ? 3 : 2) : 0))) - 64'h1;
            note(x, m, b + (o ? (t == 8 ? 3 : 2) : 0));
        end
    endtask

    // Oldest note against each format as it appears
    always @(posedge mclk_i)
        if (rst_i === 1'b0 && fmt_valid_o === 1'b1)
        begin
            checked++;
            if (notes.size() == 0)
                miss("unexpected format");
            else if ((fmt_word_o & notes[0].m) !== notes[0].w || fmt_len_o !== notes[0].l)
                miss("format contents");
            if (notes.size() != 0) void'(notes.pop_front());
        end

    initial
    begin
        {rst_i, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i} = {1'b1, 1'b1, 43'h0};
        {trace_valid_i, instr_complete_code_i, trace_type_i, trace_end_flag_i} = 8'h0;
        {trace_mode_field_i, icache_miss_flag_i, call_return_hint_i} = 3'h0;
        {loadstore_miss_flag_i, wait_state_i, addr_data_i, pc_value_i} = 66'h0;
        {overflow_i, ovf, loadstore_miss_flag} = 3'h0;
        {byte_order_field_i, cc} = 19'h0;
        void'($urandom(32'h1b62cdb0));
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(ctrl_a_offset, ctrl_a_reset, 32'hffffffff);
        rd(ctrl_b_offset, ctrl_b_reset, 32'hffffffff);
        rd(ctrl_c_offset, {28'h0, order_field_width_reset}, 32'hf);
        bus(8'h40, 1'b1, 32'hffffffff);
        rd(8'h40, 32'h0, 32'hffffffff);
        bus(ctrl_b_offset, 1'b1, 32'h1 << ca_bit);
        bus(ctrl_a_offset, 1'b1, 32'h1 << trace_on_bit);
        phase(1'b0, 1'b0);
        // Cycle accuracy off: stalls leave no trace
        bus(ctrl_a_offset, 1'b1, 32'h0);
        bus(ctrl_b_offset, 1'b1, 32'h0);
        bus(ctrl_a_offset, 1'b1, 32'h2);
        cc = 3'h0;
        send(3'h0, 1'b0, 1'b0);
        bus(ctrl_a_offset, 1'b1, 32'h0);
        bus(ctrl_b_offset, 1'b1, (32'h1 << miss_fcr_bit) | 32'h1);
        bus(ctrl_a_offset, 1'b1, 32'h2);
        phase(1'b1, 1'b0);
        bus(ctrl_a_offset, 1'b1, 32'h0);
        // Width is latched while off, so it must settle before trace goes on
        bus(ctrl_a_offset, 1'b1, 32'h1);
        bus(ctrl_a_offset, 1'b1, 32'h3);
        phase(1'b1, 1'b1);
        // Overflow, then a full program counter for resynchronisation
        ovf = 1'b1;
        cc = 3'h0;
        send(3'h0, 1'b0, 1'b0);
        note(64'h8, 64'hf, 4);
        ovf = 1'b0;
        send(3'h3, 1'b0, 1'b0);
        x = {21'h0, pc_value_i, trace_mode_field_i, 1'b0, data_trace_code, 6'h0};
        x = x | ({62'h0, icache_miss_flag_i, call_return_hint_i} << 43);
        note(x, (64'h1 << 45) - 64'h1, 45);
        // Not cycle accurate with the drop bit: lowest header bit removed
        bus(ctrl_a_offset, 1'b1, 32'h0);
        bus(ctrl_b_offset, 1'b1, 32'h1 << drop_lsb_bit);
        bus(ctrl_a_offset, 1'b1, 32'h2);
        cc = 3'h5;
        send(3'h2, 1'b0, 1'b0);
        x = {38'h0, addr_data_i[15:0], trace_mode_field_i, 1'b0, 3'h2, cc, 2'b00};
        note(x, (64'h1 << 26) - 64'h1, 26);
        repeat (100) @(posedge mclk_i);
        checked++;
        if (bit_count !== 16'(tot) || notes.size() != 0) miss("stream bit count");
        finish_test();
    end
endmodule // tb_top

bind trace_format_encoder trace_enc_asserts trace_enc_asserts_inst (.mclk_i(mclk_i),
    .rst_i(rst_i), .trace_valid_i(trace_valid_i), .trace_type_i(trace_type_i),
    .instr_complete_code_i(instr_complete_code_i), .trace_end_flag_i(trace_end_flag_i),
    .overflow_i(overflow_i), .wait_state_i(wait_state_i), .fmt_valid_o(fmt_valid_o),
    .fmt_word_o(fmt_word_o), .fmt_len_o(fmt_len_o), .trace_bit_o(trace_bit_o),
    .trace_bit_valid_o(trace_bit_valid_o));
`default_nettype wire
